// >>> verilog/scbc_consts.svh
// Offsets, field positions, reset values and timing counts for the block
`ifndef SCBC_CONSTS_SVH
`define SCBC_CONSTS_SVH
// Register index within a channel window (address bits 4:2)
`define SCBC_IDX_SYSCLK 3'h0
`define SCBC_IDX_MODE 3'h1
`define SCBC_IDX_BAUD 3'h2
`define SCBC_IDX_FRAC 3'h3
`define SCBC_IDX_STAT 3'h4
// Channel window stride in bytes, selected by address bit 5
`define SCBC_CH_STRIDE 6'h20
// Field positions
`define SCBC_SYS_PRCK_LSB 0
`define SCBC_SYS_GEAR_LSB 2
`define SCBC_MODE_MODE_LSB 0
`define SCBC_MODE_SRC_LSB 2
`define SCBC_MODE_PE_BIT 4
`define SCBC_MODE_WU_BIT 5
`define SCBC_MODE_IOC_BIT 6
`define SCBC_BAUD_DIV_LSB 0
`define SCBC_BAUD_TAP_LSB 4
`define SCBC_BAUD_FE_BIT 6
`define SCBC_FRAC_K_LSB 0
`define SCBC_STAT_FAULT_BIT 0
// Reset values
`define SCBC_RST_PRCK 2'h0
`define SCBC_RST_GEAR 3'h0
`define SCBC_RST_PER_CNT 5'h1F
// Encodings and timing
`define SCBC_PRCK_FC16 2'h2
`define SCBC_GEAR_MAX 3'h4
`define SCBC_UART_OVERSAMPLE 16
`define SCBC_FC_PERIOD_NS 25
`define SCBC_EXT_UART_MIN_NS 100
`define SCBC_EXT_IO_MIN_NS 400
`define SCBC_EXT_UART_MIN_CYC \
  ((`SCBC_EXT_UART_MIN_NS + `SCBC_FC_PERIOD_NS - 1) / `SCBC_FC_PERIOD_NS)
`define SCBC_EXT_IO_MIN_CYC \
  ((`SCBC_EXT_IO_MIN_NS + `SCBC_FC_PERIOD_NS - 1) / `SCBC_FC_PERIOD_NS)
`endif

// >>> verilog/scbc_pkg.sv
// Types shared by the serial baud clocking block
package scbc_pkg;
  localparam int unsigned SCBC_MAX_CH = 2;
  typedef enum logic [1:0] {
    SCBC_MODE_IO = 2'h0,
    SCBC_MODE_7B = 2'h1,
    SCBC_MODE_8B = 2'h2,
    SCBC_MODE_9B = 2'h3
  } scbc_mode_e;
  typedef enum logic [1:0] {
    SCBC_SRC_BAUD = 2'h0,
    SCBC_SRC_SYS = 2'h1,
    SCBC_SRC_TMR = 2'h2,
    SCBC_SRC_EXT = 2'h3
  } scbc_src_e;
  typedef struct packed {
    scbc_mode_e mode;
    scbc_src_e src;
    logic pe;
    logic wu;
    logic ioc;
    logic [3:0] div;
    logic [1:0] tap;
    logic fe;
    logic [3:0] k;
  } scbc_cfg_s;
  typedef struct packed {
    logic [3:0] gdiv;
    logic [1:0] quad;
    logic [5:0] pcnt;
    logic [3:0] taps;
  } scbc_presc_s;
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_prev;
    logic rx_s1;
    logic rx_s2;
    logic [4:0] bg_cnt;
    logic [3:0] acc;
    logic extend;
    logic bg_tick;
    logic io_half;
    logic sclk_oe;
    logic [3:0] basic_cnt;
    logic [1:0] samp;
    logic vote;
    logic vote_valid;
    logic bit_tick;
    logic [4:0] per_cnt;
    logic fault;
    logic need_presc;
  } scbc_chan_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [1:0] prck;
    logic [2:0] gear;
    scbc_cfg_s [SCBC_MAX_CH-1:0] cfg;
    logic [SCBC_MAX_CH-1:0] fault_clr;
  } scbc_top_s;

  // Divisor field 0 means 16
  function automatic logic [4:0] scbc_div_n(input logic [3:0] d);
    scbc_div_n = (d == 4'h0) ? 5'h10 : {1'b0, d};
  endfunction : scbc_div_n
endpackage : scbc_pkg

// >>> verilog/scbc_tap_if.sv
// Prescaler tap pulses shared by both channels
`timescale 1ns/1ps
interface scbc_tap_if;
  logic [3:0] tap;
  modport src (output tap);
  modport dst (input tap);
endinterface : scbc_tap_if

// >>> verilog/scbc_prescaler.sv
// Shared 6-bit prescaler with gear and four tap pulses
`timescale 1ns/1ps
`include "scbc_consts.svh"
module scbc_prescaler
  import scbc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [1:0] prck,
  input wire logic [2:0] gear,
  scbc_tap_if.src taps
);
  scbc_presc_s s;
  scbc_presc_s next_s;
  logic fc16;
  logic [2:0] gear_c;
  logic [4:0] src_len;

  // Source is fc/16, or fc geared down by a power of two
  assign fc16 = (prck == `SCBC_PRCK_FC16);
  assign gear_c = (gear > `SCBC_GEAR_MAX) ? `SCBC_GEAR_MAX : gear;
  assign src_len = fc16 ? 5'h10 : (5'h01 << gear_c);

  // Divide source by 4 into the base tap (held off with fc/16), then 6-bit count
  always_comb
  begin
    next_s = s;
    next_s.taps = 4'h0;
    if (!run)
    begin
      next_s.gdiv = 4'h0;
      next_s.quad = 2'h0;
      next_s.pcnt = 6'h00;
    end
    else if ({1'b0, s.gdiv} == src_len - 5'h01)
    begin
      next_s.gdiv = 4'h0;
      next_s.quad = s.quad + 2'h1;
      if (s.quad == 2'h3)
      begin
        next_s.pcnt = s.pcnt + 6'h01;
        next_s.taps[0] = !fc16;
        next_s.taps[1] = (s.pcnt[1:0] == 2'h3);
        next_s.taps[2] = (s.pcnt[3:0] == 4'hF);
        next_s.taps[3] = (s.pcnt == 6'h3F);
      end
    end
    else
      next_s.gdiv = s.gdiv + 4'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign taps.tap = s.taps;

  AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    !run |=> s.taps == 4'h0)
    else $error("prescaler tap while stopped");
  AST_FC16_NO_T0: assert property (@(posedge aclk) disable iff (!aresetn)
    s.taps[0] |-> $past(prck) != `SCBC_PRCK_FC16)
    else $error("base tap used with fc/16 source");
  AST_TAP_NEST: assert property (@(posedge aclk) disable iff (!aresetn)
    s.taps[3] |-> s.taps[2] && s.taps[1] && s.pcnt == 6'h00)
    else $error("slow tap not aligned to faster taps");
endmodule : scbc_prescaler

// >>> verilog/scbc_channel.sv
// Per-channel baud generator, basic clock and receive bit voter
`timescale 1ns/1ps
`include "scbc_consts.svh"
module scbc_channel
  import scbc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  scbc_tap_if.dst taps,
  input wire scbc_cfg_s cfg,
  input wire logic timer_trig,
  input wire logic rx_pin,
  input wire logic sclk_in,
  input wire logic fault_clr,
  output scbc_chan_s st
);
  scbc_chan_s s;
  scbc_chan_s next_s;
  logic [4:0] n;
  logic uart;
  logic frac_on;
  logic tap_tick;
  logic ext_rise;
  logic ext_used;
  logic basic;
  logic bg_hit;
  logic [4:0] sum;
  logic [4:0] ext_min;

  assign n = scbc_div_n(cfg.div);
  assign uart = (cfg.mode != SCBC_MODE_IO);
  // Fraction only in UART with N 2..15; guards a bad setting
  assign frac_on = cfg.fe && uart && n >= 5'h02 && n <= 5'h0F;
  assign tap_tick = taps.tap[cfg.tap];
  assign bg_hit = ({1'b0, s.bg_cnt} >= {1'b0, n} - 6'h01 + {5'h00, s.extend});
  assign sum = {1'b0, s.acc} + (5'h10 - {1'b0, cfg.k});
  assign ext_rise = s.sclk_s2 && !s.sclk_prev;
  assign ext_used = uart ? (cfg.src == SCBC_SRC_EXT) : cfg.ioc;
  assign ext_min = uart ? 5'(`SCBC_EXT_UART_MIN_CYC)
                        : 5'(`SCBC_EXT_IO_MIN_CYC);

  // Basic clock source for UART mode
  always_comb
  begin
    unique case (cfg.src)
      SCBC_SRC_BAUD: basic = s.bg_tick;
      SCBC_SRC_SYS: basic = 1'b1;
      SCBC_SRC_TMR: basic = timer_trig;
      SCBC_SRC_EXT: basic = ext_rise;
    endcase
  end

  always_comb
  begin
    next_s = s;
    next_s.sclk_s1 = sclk_in;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_prev = s.sclk_s2;
    next_s.rx_s1 = rx_pin;
    next_s.rx_s2 = s.rx_s1;
    next_s.bg_tick = 1'b0;
    next_s.bit_tick = 1'b0;
    next_s.vote_valid = 1'b0;
    // Baud generator: period N, stretched by one when fraction overflows
    if (tap_tick)
    begin
      if (bg_hit)
      begin
        next_s.bg_cnt = 5'h00;
        next_s.bg_tick = 1'b1;
        next_s.acc = frac_on ? sum[3:0] : 4'h0;
        next_s.extend = frac_on && sum[4];
      end
      else
        next_s.bg_cnt = s.bg_cnt + 5'h01;
    end
    if (uart)
    begin
      next_s.io_half = 1'b0;
      if (basic)
      begin
        next_s.basic_cnt = s.basic_cnt + 4'h1;
        next_s.bit_tick = (s.basic_cnt == 4'hF);
        if (s.basic_cnt >= 4'h6 && s.basic_cnt <= 4'h7)
          next_s.samp = {s.samp[0], s.rx_s2};
        if (s.basic_cnt == 4'h8)
        begin
          next_s.vote = (s.samp[1] & s.samp[0]) | (s.samp[1] & s.rx_s2) |
                        (s.samp[0] & s.rx_s2);
          next_s.vote_valid = 1'b1;
        end
      end
    end
    else
    begin
      next_s.basic_cnt = 4'h0;
      // Internal shift clock is generator output halved
      if (!cfg.ioc && s.bg_tick)
      begin
        next_s.io_half = !s.io_half;
        next_s.bit_tick = s.io_half;
      end
      else if (cfg.ioc)
      begin
        next_s.io_half = 1'b0;
        next_s.bit_tick = ext_rise;
      end
      if (next_s.bit_tick)
      begin
        next_s.vote = s.rx_s2;
        next_s.vote_valid = 1'b1;
      end
    end
    next_s.sclk_oe = !uart && !cfg.ioc;
    // Prescaler only needed while the generator feeds the channel
    next_s.need_presc = uart ? (cfg.src == SCBC_SRC_BAUD) : !cfg.ioc;
    // External clock period check; a fault set beats a clear
    if (ext_rise)
      next_s.per_cnt = 5'h01;
    else if (s.per_cnt != 5'h1F)
      next_s.per_cnt = s.per_cnt + 5'h01;
    if (fault_clr)
      next_s.fault = 1'b0;
    if (ext_rise && ext_used && s.per_cnt < ext_min)
      next_s.fault = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      // Edge chain starts at the idle-high pin level, no false edge
      s.sclk_s1 <= 1'b1;
      s.sclk_s2 <= 1'b1;
      s.sclk_prev <= 1'b1;
      s.per_cnt <= `SCBC_RST_PER_CNT;
    end
    else
      s <= next_s;
  end

  assign st = s;

  AST_UART_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    s.bit_tick && $past(uart) |-> s.basic_cnt == 4'h0 &&
      $past(s.basic_cnt) == 4'hF)
    else $error("UART bit tick not on 16th basic pulse");
  AST_IO_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    s.bit_tick && $past(!uart && !cfg.ioc) |-> $fell(s.io_half))
    else $error("I/O bit tick not at shift clock fall");
  AST_VOTE: assert property (@(posedge aclk) disable iff (!aresetn)
    s.vote_valid && $past(uart) |-> $past(s.basic_cnt) == 4'h8)
    else $error("vote not on 9th basic pulse");
  AST_INT_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
    s.bg_tick && $past(!frac_on) |-> !s.extend && s.acc == 4'h0)
    else $error("fraction used while disabled");
  AST_EXT_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_rise && ext_used && s.per_cnt < ext_min |=> s.fault)
    else $error("short external clock period not flagged");
endmodule : scbc_channel

// >>> verilog/scbc_top.sv
// Serial baud clocking top: AXI4-Lite registers, prescaler, one or two channels (CH_COUNT)
`timescale 1ns/1ps
`include "scbc_consts.svh"
module scbc_top
  import scbc_pkg::*;
#(
  parameter int unsigned CH_COUNT = 2
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic timer_trigger,
  input wire logic [CH_COUNT-1:0] receive_pin,
  input wire logic [CH_COUNT-1:0] shift_clock_pin_in,
  output logic [CH_COUNT-1:0] shift_clock_pin_out,
  output logic [CH_COUNT-1:0] shift_clock_pin_oe,
  output logic [CH_COUNT-1:0] bit_tick,
  output logic [CH_COUNT-1:0] rx_bit,
  output logic [CH_COUNT-1:0] rx_bit_valid
);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  if (CH_COUNT < 1 || CH_COUNT > SCBC_MAX_CH)
  begin : g_bad_count
    $error("CH_COUNT must be 1 or 2");
  end

  scbc_top_s s;
  scbc_top_s next_s;
  scbc_chan_s ch_st [SCBC_MAX_CH];
  logic [SCBC_MAX_CH-1:0] need;
  logic have_aw;
  logic have_w;
  logic [5:0] wa;
  logic [7:0] wd;
  logic ws;
  logic [7:0] rd_val;
  logic rd_ok;

  scbc_tap_if tap_bus ();

  // Register map check, shared by read and write
  function automatic logic reg_ok(input logic [5:0] a);
    logic ch;
    logic [2:0] idx;
    ch = a[5];
    idx = a[4:2];
    reg_ok = (a[1:0] == 2'h0) && (idx <= `SCBC_IDX_STAT) &&
             !(ch && idx == `SCBC_IDX_SYSCLK) &&
             (32'(ch) < CH_COUNT);
  endfunction : reg_ok

  // Status word: fault, last bit, parity, wake-up, frame data bits
  function automatic logic [7:0] stat_val(input scbc_cfg_s c,
                                           input scbc_chan_s st);
    logic par;
    logic wake;
    logic [3:0] bits;
    par = c.pe && (c.mode == SCBC_MODE_7B || c.mode == SCBC_MODE_8B);
    wake = c.wu && (c.mode == SCBC_MODE_9B);
    unique case (c.mode)
      SCBC_MODE_7B: bits = 4'h7;
      SCBC_MODE_9B: bits = 4'h9;
      default: bits = 4'h8;
    endcase
    stat_val = {bits, wake, par, st.vote, st.fault};
  endfunction : stat_val

  // Read mux
  always_comb
  begin
    rd_ok = reg_ok(araddr);
    rd_val = 8'h00;
    if (rd_ok)
    begin
      unique case (araddr[4:2])
        `SCBC_IDX_SYSCLK: rd_val = {3'h0, s.gear, s.prck};
        `SCBC_IDX_MODE: rd_val = {1'b0, s.cfg[araddr[5]].ioc,
          s.cfg[araddr[5]].wu, s.cfg[araddr[5]].pe,
          s.cfg[araddr[5]].src, s.cfg[araddr[5]].mode};
        `SCBC_IDX_BAUD: rd_val = {1'b0, s.cfg[araddr[5]].fe,
          s.cfg[araddr[5]].tap, s.cfg[araddr[5]].div};
        `SCBC_IDX_FRAC: rd_val = {4'h0, s.cfg[araddr[5]].k};
        default: rd_val = stat_val(s.cfg[araddr[5]], ch_st[araddr[5]]);
      endcase
    end
  end

  // Write side takes address and data in either order
  assign have_aw = s.aw_held || (awvalid && s.awready);
  assign have_w = s.w_held || (wvalid && s.wready);
  assign wa = s.aw_held ? s.waddr : awaddr;
  assign wd = s.w_held ? s.wdata : wdata[7:0];
  assign ws = s.w_held ? s.wstrb0 : wstrb[0];

  always_comb
  begin
    next_s = s;
    next_s.fault_clr = '0;
    if (awvalid && s.awready)
    begin
      next_s.awready = 1'b0;
      next_s.aw_held = 1'b1;
      next_s.waddr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.wready = 1'b0;
      next_s.w_held = 1'b1;
      next_s.wdata = wdata[7:0];
      next_s.wstrb0 = wstrb[0];
    end
    if (have_aw && have_w && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = reg_ok(wa) ? RESP_OKAY : RESP_SLVERR;
      // Only byte lane 0 carries register bits
      if (reg_ok(wa) && ws)
      begin
        unique case (wa[4:2])
          `SCBC_IDX_SYSCLK:
          begin
            next_s.prck = wd[`SCBC_SYS_PRCK_LSB +: 2];
            next_s.gear = wd[`SCBC_SYS_GEAR_LSB +: 3];
          end
          `SCBC_IDX_MODE:
          begin
            next_s.cfg[wa[5]].mode = scbc_mode_e'(wd[`SCBC_MODE_MODE_LSB +: 2]);
            next_s.cfg[wa[5]].src = scbc_src_e'(wd[`SCBC_MODE_SRC_LSB +: 2]);
            next_s.cfg[wa[5]].pe = wd[`SCBC_MODE_PE_BIT];
            next_s.cfg[wa[5]].wu = wd[`SCBC_MODE_WU_BIT];
            next_s.cfg[wa[5]].ioc = wd[`SCBC_MODE_IOC_BIT];
          end
          `SCBC_IDX_BAUD:
          begin
            next_s.cfg[wa[5]].div = wd[`SCBC_BAUD_DIV_LSB +: 4];
            next_s.cfg[wa[5]].tap = wd[`SCBC_BAUD_TAP_LSB +: 2];
            next_s.cfg[wa[5]].fe = wd[`SCBC_BAUD_FE_BIT];
          end
          `SCBC_IDX_FRAC: next_s.cfg[wa[5]].k = wd[`SCBC_FRAC_K_LSB +: 4];
          default: next_s.fault_clr[wa[5]] = wd[`SCBC_STAT_FAULT_BIT];
        endcase
      end
    end
    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    // Read answers on the edge after the address is taken
    if (arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      next_s.rdata = rd_val;
    end
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.prck <= `SCBC_RST_PRCK;
      s.gear <= `SCBC_RST_GEAR;
    end
    else
      s <= next_s;
  end

  // Shared prescaler, run while any channel asks for it
  scbc_prescaler u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(|need),
    .prck(s.prck),
    .gear(s.gear),
    .taps(tap_bus.src)
  );

  // Independent channels, each with its own pins and settings
  for (genvar c = 0; c < SCBC_MAX_CH; c++)
  begin : g_ch
    if (c < CH_COUNT)
    begin : g_on
      scbc_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .taps(tap_bus.dst),
        .cfg(s.cfg[c]),
        .timer_trig(timer_trigger),
        .rx_pin(receive_pin[c]),
        .sclk_in(shift_clock_pin_in[c]),
        .fault_clr(s.fault_clr[c]),
        .st(ch_st[c])
      );
      assign need[c] = ch_st[c].need_presc;
      assign shift_clock_pin_out[c] = ch_st[c].io_half;
      assign shift_clock_pin_oe[c] = ch_st[c].sclk_oe;
      assign bit_tick[c] = ch_st[c].bit_tick;
      assign rx_bit[c] = ch_st[c].vote;
      assign rx_bit_valid[c] = ch_st[c].vote_valid;
    end
    else
    begin : g_off
      assign ch_st[c] = '0;
      assign need[c] = 1'b0;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = {24'h000000, s.rdata};

  AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s.bvalid && !bready |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped before taken");
  AST_R_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && s.arready |=> s.rvalid && !s.arready)
    else $error("read not answered on next edge");
endmodule : scbc_top

// >>> sim/scbc_peer.sv
// Behavioural external serial peer: shift clock and receive data
`timescale 1ns/1ps
module scbc_peer
(
  input wire logic en,
  input wire logic [9:0] half_ns,
  input wire logic data,
  output logic sclk,
  output logic rxd
);
  // Clock idles high between transfers; odd start keeps it off aclk edges
  initial sclk = 1'b1;
  always
  begin
    if (en)
    begin
      #(half_ns) sclk = ~sclk; // bench picks the period
    end
    else
    begin
      #7 sclk = 1'b1;
    end
  end
  // Receive line simply follows the requested level
  assign rxd = data;
endmodule : scbc_peer

// >>> sim/scbc_top_tb.sv
// Self-checking bench for the serial baud clocking block
`timescale 1ns/1ps
module scbc_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic timer_trigger = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [1:0] rxp, sci, sco, scoe, btk, rxb, rxv;
  logic [1:0] p_en = 2'h0;
  logic [1:0] p_dat = 2'h3;
  logic [9:0] p_half [2] = '{10'd100, 10'd100};
  logic tmr_on = 1'b0;
  logic [1:0] tcnt = 2'h0;
  int n_errors = 0;
  int num_checks = 0;

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  scbc_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .timer_trigger(timer_trigger), .receive_pin(rxp),
    .shift_clock_pin_in(sci), .shift_clock_pin_out(sco),
    .shift_clock_pin_oe(scoe), .bit_tick(btk), .rx_bit(rxb),
    .rx_bit_valid(rxv));
  scbc_peer i_peer0 (.en(p_en[0]), .half_ns(p_half[0]), .data(p_dat[0]),
    .sclk(sci[0]), .rxd(rxp[0]));
  scbc_peer i_peer1 (.en(p_en[1]), .half_ns(p_half[1]), .data(p_dat[1]),
    .sclk(sci[1]), .rxd(rxp[1]));

  // Timer trigger pulse every third cycle while enabled
  always @(posedge aclk)
  begin
    tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
    timer_trigger <= tmr_on && (tcnt == 2'h2);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic hang;
    n_errors++;
    $display("[FAIL] %0t wait timed out", $time);
    wrap_up();
  endtask : hang

  // Bus write; values read right after an edge are the sampled ones
  task automatic wr(input logic [5:0] a, input logic [7:0] v,
                    output logic [1:0] rs);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
        break;
    end
    if (i == 100)
      hang();
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
        break;
    end
    if (i == 100)
      hang();
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  // Edges until the next bit strobe or vote strobe of a channel
  task automatic pulse(input int ch, input bit vote, output int n);
    for (n = 1; n <= 9000; n++)
    begin
      @(posedge aclk);
      if (vote ? rxv[ch] : btk[ch])
        break;
    end
    if (n > 9000)
      hang();
  endtask : pulse

  // Third strobe spacing skips the settling after a new setting
  task automatic per(input int ch, input int exp);
    int n;
    pulse(ch, 1'b0, n);
    pulse(ch, 1'b0, n);
    pulse(ch, 1'b0, n);
    chk(n, exp);
  endtask : per

  task automatic t_regs;
    wr(6'h08, 8'h75, r);
    chk({30'h0, r}, 32'h0);
    rd(6'h08, d, r);
    chk({30'h0, r}, 32'h0);
    chk(d, 32'h75);
    rd(6'h20, d, r);
    chk({30'h0, r}, 32'h2);
    wr(6'h14, 8'h01, r);
    chk({30'h0, r}, 32'h2);
    $display("regs done");
  endtask : t_regs

  task automatic t_modes;
    for (int i = 0; i < 4; i++)
    begin
      wr(6'h04, 8'h30 | 8'(i), r);
      rd(6'h10, d, r);
      chk(d[7:4], (i == 0) ? 4'h8 : 4'(6 + i));
      chk(d[2], i == 1 || i == 2);
      chk(d[3], i == 3);
    end
    $display("modes done");
  endtask : t_modes

  // System ctl, mode, baud ctl, fraction, expected bit period in aclk
  task automatic t_rates;
    logic [47:0] t [10] = '{48'h00_01_02_00_0080, 48'h00_01_00_00_0400,
      48'h00_01_11_00_0100, 48'h04_01_01_00_0080, 48'h02_01_11_00_1000,
      48'h00_01_42_08_00A0, 48'h00_00_02_00_0010, 48'h00_05_02_00_0010,
      48'h00_01_21_00_0400, 48'h1C_01_01_00_0400};
    wr(6'h24, 8'h05, r);
    for (int i = 0; i < 10; i++)
    begin
      wr(6'h00, t[i][47:40], r);
      wr(6'h04, t[i][39:32], r);
      wr(6'h08, t[i][31:24], r);
      wr(6'h0C, t[i][23:16], r);
      per(0, int'(t[i][15:0]));
    end
    per(1, 16);
    $display("rates done");
  endtask : t_rates

  task automatic t_src;
    int n;
    tmr_on <= 1'b1;
    wr(6'h04, 8'h09, r);
    per(0, 48);
    tmr_on <= 1'b0;
    p_en[0] <= 1'b1;
    wr(6'h04, 8'h0D, r);
    per(0, 128);
    rd(6'h10, d, r);
    chk(d[0], 1'b0);
    p_half[0] <= 10'd25;
    pulse(0, 1'b0, n);
    pulse(0, 1'b0, n);
    rd(6'h10, d, r);
    chk(d[0], 1'b1);
    p_half[0] <= 10'd100;
    pulse(0, 1'b0, n);
    wr(6'h10, 8'h01, r);
    rd(6'h10, d, r);
    chk(d[0], 1'b0);
    p_half[0] <= 10'd250;
    wr(6'h04, 8'h40, r);
    per(0, 20);
    chk(scoe[0], 1'b0);
    p_en[0] <= 1'b0;
    wr(6'h04, 8'h00, r);
    rd(6'h04, d, r);
    chk(scoe[0], 1'b1);
    $display("sources done");
  endtask : t_src

  task automatic t_vote;
    int n;
    wr(6'h04, 8'h05, r);
    for (int v = 0; v < 2; v++)
    begin
      p_dat[0] <= v[0];
      pulse(0, 1'b1, n);
      pulse(0, 1'b1, n);
      chk(rxb[0], v[0]);
    end
    $display("vote done");
  endtask : t_vote

  // Reset for five cycles, then the scenarios in turn
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_modes();
    t_rates();
    t_src();
    t_vote();
    wrap_up();
  end
endmodule : scbc_top_tb
